// *** rtl/roc_clk_gen.sv ***
// prescaled clock output generator: one phase accumulator stepped by the
// 16 MHz reference increment shifted right by the prescale of the rate code
// assumes rate_code and run come from logic on the same clock
`timescale 1ns/1ps
module roc_clk_gen
    import roc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic [2:0] rate_code,
    input  wire logic       run,
    // output
    output logic            clk_out,
    output logic [2:0]      live_code
);
    logic [31:0] acc_q;
    logic [31:0] acc_sum;
    logic [2:0]  want_code;
    logic        fall_edge;

    // every rate is the one reference divided by a power of two
    function automatic logic [31:0] step_of(input logic [2:0] code);
        unique case (code)
            ROC_RATE_OFF:  step_of = 32'h0;
            ROC_RATE_1M:   step_of = ROC_STEP_REF >> 4;
            ROC_RATE_2M:   step_of = ROC_STEP_REF >> 3;
            ROC_RATE_4M:   step_of = ROC_STEP_REF >> 2;
            ROC_RATE_8M:   step_of = ROC_STEP_REF >> 1;
            ROC_RATE_16M:  step_of = ROC_STEP_REF;
            ROC_RATE_250K: step_of = ROC_STEP_REF >> 6;
            ROC_RATE_62K5: step_of = ROC_STEP_REF >> 8;
        endcase
    endfunction

    assign want_code = run ? rate_code : ROC_RATE_OFF;
    assign acc_sum   = acc_q + step_of(live_code);
    assign fall_edge = acc_q[31] & ~acc_sum[31];

    // a change from a running rate waits for a falling edge so no runt pulse escapes; one out of off takes effect at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q     <= 32'h0;
            // idle until run first rises, so no pulse leaves before the reference settles
            live_code <= ROC_RATE_OFF;
        end else if (want_code != live_code &&
                     (live_code == ROC_RATE_OFF || fall_edge)) begin
            acc_q     <= 32'h0;
            live_code <= want_code;
        end else begin
            acc_q     <= acc_sum;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out <= 1'b0;
        end else begin
            clk_out <= (live_code == ROC_RATE_OFF) ? 1'b0 : acc_q[31];
        end
    end
endmodule

// *** rtl/roc_clk_out_ctrl.sv ***
// reference oscillator control and prescaled clock output with register port
// assumes register strobes come from logic on clk; sleep_pin is asynchronous;
// power_on_rst precedes the first rst and is the only reset of the live rate
`timescale 1ns/1ps
module roc_clk_out_ctrl
    import roc_pkg::*;
#(
    parameter int SETTLE_CYCLES = ROC_SETTLE_CYCLES
) (
    // clock and resets
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_on_rst,
    // register port
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [5:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    output logic            reg_rd_valid,
    // sleep pin
    input  wire logic       sleep_pin,
    // oscillator controls
    output logic [3:0]      osc_load_trim,
    output logic [3:0]      osc_source_select,
    output logic            osc_enable,
    output logic            ext_ref_select,
    output logic            ref_ready,
    // clock output pin and drive
    output logic            master_clock_out_pin,
    output logic [1:0]      clock_out_drive_select,
    output logic [1:0]      pad_drive
);
    // the settling counter is 20 bits wide
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 2**20 - 1) begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    roc_clk_ctrl_s clk_ctrl_q;
    roc_osc_ctrl_s osc_ctrl_q;
    logic [2:0]    live_rate_q;
    logic [19:0]   settle_q;
    logic          sleep_sync;
    logic          sleep_q;
    logic          sleep_exit;
    logic          wr_clk_ctrl;
    logic          wr_osc_ctrl;
    logic          immediate;
    logic [2:0]    gen_code;
    logic          gen_out;
    roc_clk_ctrl_s wr_clk;

    roc_sync2 u_sleep_sync (
        .clk      (clk),
        .rst      (power_on_rst),
        .async_in (sleep_pin),
        .sync_out (sleep_sync)
    );

    assign wr_clk      = reg_wdata;
    assign wr_clk_ctrl = reg_wr_en && reg_addr == ROC_ADDR_CLK_OUT_CTRL;
    assign wr_osc_ctrl = reg_wr_en && reg_addr == ROC_ADDR_OSC_CTRL;
    assign sleep_exit  = sleep_q && !sleep_sync;
    assign immediate   = !clk_ctrl_q.clock_out_update_select ||
                         clk_ctrl_q.clock_out_rate_code == ROC_RATE_OFF;

    always_ff @(posedge clk or posedge power_on_rst) begin
        if (power_on_rst) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_sync;
        end
    end

    // register file, loaded with its reset values by the device reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_ctrl_q <= ROC_CLK_CTRL_RST;
        end else if (wr_clk_ctrl) begin
            clk_ctrl_q <= wr_clk;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_ctrl_q <= ROC_OSC_CTRL_RST;
        end else if (wr_osc_ctrl) begin
            osc_ctrl_q <= reg_wdata;
        end
    end

    // live rate is the shadow copy: the device reset does not touch it
    always_ff @(posedge clk or posedge power_on_rst) begin
        if (power_on_rst) begin
            live_rate_q <= ROC_RATE_1M;
        end else if (sleep_exit) begin
            live_rate_q <= clk_ctrl_q.clock_out_rate_code;
        end else if (!rst && wr_clk_ctrl && immediate) begin
            live_rate_q <= wr_clk.clock_out_rate_code;
        end
    end

    // settling count restarts at power-up and at each sleep exit
    always_ff @(posedge clk or posedge power_on_rst) begin
        if (power_on_rst) begin
            settle_q  <= 20'h0;
            ref_ready <= 1'b0;
        end else if (sleep_sync) begin
            settle_q  <= 20'h0;
            ref_ready <= 1'b0;
        end else if (!ref_ready) begin
            settle_q  <= settle_q + 20'h1;
            ref_ready <= settle_q == 20'(SETTLE_CYCLES - 1);
        end
    end

    roc_clk_gen u_clk_gen (
        .clk       (clk),
        .rst       (power_on_rst),
        .rate_code (live_rate_q),
        .run       (ref_ready),
        .clk_out   (gen_out),
        .live_code (gen_code)
    );

    assign master_clock_out_pin = gen_out;

    // pin-facing controls from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_load_trim          <= ROC_OSC_CTRL_RST.osc_load_trim;
            osc_source_select      <= ROC_OSC_CTRL_RST.osc_source_select;
            osc_enable             <= 1'b0;
            ext_ref_select         <= 1'b0;
            clock_out_drive_select <= ROC_CLK_CTRL_RST.clock_out_drive_select;
            pad_drive              <= ROC_CLK_CTRL_RST.pad_drive;
        end else begin
            osc_load_trim          <= osc_ctrl_q.osc_load_trim;
            osc_source_select      <= osc_ctrl_q.osc_source_select;
            osc_enable             <= !sleep_sync &&
                                      osc_ctrl_q.osc_source_select == ROC_SRC_CRYSTAL;
            ext_ref_select         <= osc_ctrl_q.osc_source_select == ROC_SRC_EXTERNAL;
            clock_out_drive_select <= clk_ctrl_q.clock_out_drive_select;
            pad_drive              <= clk_ctrl_q.pad_drive;
        end
    end

    // read port, one cycle latency, unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                unique case (reg_addr)
                    ROC_ADDR_CLK_OUT_CTRL: reg_rdata <= clk_ctrl_q;
                    ROC_ADDR_OSC_CTRL:     reg_rdata <= osc_ctrl_q;
                    ROC_ADDR_STATUS:       reg_rdata <= {2'h0, sleep_sync, ref_ready,
                                                         1'b0, gen_code};
                    default:               reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

// *** rtl/roc_pkg.sv ***
// constants, field layouts and carrier types of the reference oscillator
// and clock output control block
// assumes a single 100 MHz system clock; the 16 MHz reference is synthesised
package roc_pkg;

    // clock rates
    localparam longint ROC_CLK_HZ        = 100_000_000;
    localparam longint ROC_REF_HZ        = 16_000_000;
    localparam int     ROC_CLK_PERIOD_NS = 10;

    // phase increment of the 16 MHz reference in a 32-bit accumulator
    localparam logic [31:0] ROC_STEP_REF = 32'((ROC_REF_HZ << 32) / ROC_CLK_HZ);

    // oscillator settling after sleep exit or power-up, least time rounds up
    localparam int ROC_SETTLE_NS     = 330_000;
    localparam int ROC_SETTLE_CYCLES = (ROC_SETTLE_NS + ROC_CLK_PERIOD_NS - 1)
                                       / ROC_CLK_PERIOD_NS;

    // register offsets
    localparam logic [5:0] ROC_ADDR_CLK_OUT_CTRL = 6'h03;
    localparam logic [5:0] ROC_ADDR_OSC_CTRL     = 6'h12;
    localparam logic [5:0] ROC_ADDR_STATUS       = 6'h3F;

    // output rate codes
    localparam logic [2:0] ROC_RATE_OFF    = 3'h0;
    localparam logic [2:0] ROC_RATE_1M     = 3'h1;
    localparam logic [2:0] ROC_RATE_2M     = 3'h2;
    localparam logic [2:0] ROC_RATE_4M     = 3'h3;
    localparam logic [2:0] ROC_RATE_8M     = 3'h4;
    localparam logic [2:0] ROC_RATE_16M    = 3'h5;
    localparam logic [2:0] ROC_RATE_250K   = 3'h6;
    localparam logic [2:0] ROC_RATE_62K5   = 3'h7;

    // oscillator source codes
    localparam logic [3:0] ROC_SRC_EXTERNAL = 4'h4;
    localparam logic [3:0] ROC_SRC_CRYSTAL  = 4'hF;

    // clock output control register: pads[7:6] drive[5:4] update_sel[3] rate[2:0]
    typedef struct packed {
        logic [1:0] pad_drive;
        logic [1:0] clock_out_drive_select;
        logic       clock_out_update_select;
        logic [2:0] clock_out_rate_code;
    } roc_clk_ctrl_s;

    // oscillator control register: source[7:4] trim[3:0]
    typedef struct packed {
        logic [3:0] osc_source_select;
        logic [3:0] osc_load_trim;
    } roc_osc_ctrl_s;

    localparam roc_clk_ctrl_s ROC_CLK_CTRL_RST = '{
        pad_drive:               2'h0,
        clock_out_drive_select:  2'h0,
        clock_out_update_select: 1'h1,
        clock_out_rate_code:     ROC_RATE_1M
    };

    localparam roc_osc_ctrl_s ROC_OSC_CTRL_RST = '{
        osc_source_select: ROC_SRC_CRYSTAL,
        osc_load_trim:     4'h0
    };

endpackage

// *** rtl/roc_sync2.sv ***
// two-flop synchroniser for a level arriving from outside the clock domain
// assumes the input is a slowly changing level
`timescale 1ns/1ps
module roc_sync2 (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // only the second flop reads the first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** tb/ref_osc_clock_output_ctrl_test.sv ***
// self-checking bench for the clock output control block
// assumes a 100 MHz clock and a settling count cut to 20 cycles
`timescale 1ns/1ps
module ref_osc_clock_output_ctrl_test;
    import roc_pkg::*;
    localparam int SETTLE = 20;
    localparam logic [5:0] CTRL = ROC_ADDR_CLK_OUT_CTRL;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       power_on_rst = 1'b1;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       sleep = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       rd_valid, osc_en, ext_ref, ready, pin;
    logic [3:0] trim, src;
    logic [1:0] drive, pads;
    int         fail_count = 0;
    int         checks_done = 0;
    int         n;
    // cycles spanned by eight output periods, per rate code
    int         exp_span[8] = '{0, 800, 400, 200, 100, 50, 3200, 12800};
    always #5 clk = ~clk;
    roc_clk_out_ctrl #(.SETTLE_CYCLES(SETTLE)) u_roc_clk_out_ctrl (
        .clk(clk), .rst(rst), .power_on_rst(power_on_rst),
        .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
        .sleep_pin(sleep), .osc_load_trim(trim), .osc_source_select(src),
        .osc_enable(osc_en), .ext_ref_select(ext_ref), .ref_ready(ready),
        .master_clock_out_pin(pin), .clock_out_drive_select(drive), .pad_drive(pads)
    );
    roc_host_model u_roc_host_model (.master_clock_out_pin(pin), .ref_ready(ready));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        cyc(1);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string s);
        addr = a;
        rd_en = 1'b1;
        cyc(1);
        rd_en = 1'b0;
        check(rdata & m, e, s);
        cyc(1);
    endtask
    // live code via status, then eight periods timed by the host
    task automatic rate(input logic [2:0] c);
        int span;
        cyc(1000);
        rchk(ROC_ADDR_STATUS, 8'h07, {5'h0, c}, "live code");
        u_roc_host_model.flush();
        for (int i = 0; i < 20000 && u_roc_host_model.edges.size() < 9; i++) cyc(1);
        span = (u_roc_host_model.edges.size() < 9) ? 0 :
               int'((u_roc_host_model.edges[8] - u_roc_host_model.edges[0]) / 10);
        if (span >= exp_span[c] - 1 && span <= exp_span[c] + 1) span = exp_span[c];
        check(span, exp_span[c], "span");
        $display("rate test code %0d done", c);
    endtask
    task automatic nap();
        int i;
        sleep = 1'b1;
        // the output only stops at its next falling edge, a full 1 MHz period at worst
        cyc(200);
        check({ready, pin}, 0, "asleep");
        sleep = 1'b0;
        for (i = 0; i < 200 && ready !== 1'b1; i++) cyc(1);
        check(i >= SETTLE, 1, "settle wait");
        $display("sleep test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        cyc(60000);
        fail_count++;
        end_of_test();
    end
    initial begin
        cyc(4);
        rst = 1'b0;
        power_on_rst = 1'b0;
        rchk(CTRL, 8'hFF, 8'h09, "ctrl reset");
        rchk(ROC_ADDR_OSC_CTRL, 8'hFF, 8'hF0, "osc reset");
        rchk(6'h20, 8'hFF, 8'h00, "unmapped");
        rate(3'h1);
        wr(CTRL, 8'h0D);
        rate(3'h1);
        nap();
        rate(3'h5);
        wr(CTRL, 8'h00);
        rate(3'h5);
        wr(CTRL, 8'h0B);
        rate(3'h3);
        wr(CTRL, 8'h00);
        nap();
        n = u_roc_host_model.edge_count;
        cyc(2000);
        check(u_roc_host_model.edge_count - n + pin, 0, "output off");
        for (int c = 1; c < 8; c++) begin
            wr(CTRL, {2'(c), 2'(c), 1'b0, 3'(c)});
            check({pads, drive}, {2'(c), 2'(c)}, "drive");
            rate(3'(c));
        end
        wr(CTRL, 8'h05);
        // leaving 62.5 kHz waits for its falling edge, up to one full period
        cyc(1600);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        rchk(CTRL, 8'hFF, 8'h09, "ctrl after reset");
        rate(3'h5);
        nap();
        rate(3'h1);
        wr(ROC_ADDR_OSC_CTRL, 8'h4A);
        rchk(ROC_ADDR_OSC_CTRL, 8'hFF, 8'h4A, "osc readback");
        check({ext_ref, osc_en, trim, src}, 10'h2A4, "external ref");
        wr(ROC_ADDR_OSC_CTRL, 8'hF0);
        cyc(1);
        check({ext_ref, osc_en, src}, 6'h1F, "crystal");
        $display("oscillator test done");
        end_of_test();
    end
endmodule

// *** tb/roc_clk_out_checker.sv ***
// port assertions for the clock output control block
// assumes binding onto roc_clk_out_ctrl, one clock domain
`timescale 1ns/1ps
module roc_clk_out_checker
    import roc_pkg::*;
#(
    parameter int SETTLE_CYCLES = 20
) (
    // clock and resets
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       power_on_rst,
    // register port and sleep pin
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd_valid,
    input wire logic       sleep_pin,
    // oscillator and pin
    input wire logic [3:0] osc_load_trim,
    input wire logic [3:0] osc_source_select,
    input wire logic       osc_enable,
    input wire logic       ext_ref_select,
    input wire logic       ref_ready,
    input wire logic       master_clock_out_pin,
    input wire logic [1:0] clock_out_drive_select,
    input wire logic [1:0] pad_drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst || power_on_rst);
    // mirrors may lag a write by up to two edges, so judge them only once settled
    logic [1:0] src_age_q;
    always_ff @(posedge clk or posedge rst or posedge power_on_rst) begin
        if (rst || power_on_rst) src_age_q <= 2'h0;
        else if (reg_wr_en && reg_addr == ROC_ADDR_OSC_CTRL) src_age_q <= 2'h0;
        else if (src_age_q != 2'h3) src_age_q <= src_age_q + 2'h1;
    end
    sequence s_wr(a);
        reg_wr_en && reg_addr == a;
    endsequence
    AST_RD_VALID: assert property (reg_rd_valid == $past(reg_rd_en))
        else $error("read valid not one cycle after strobe");
    AST_RD_HOLD: assert property (!reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_DRIVE: assert property (s_wr(ROC_ADDR_CLK_OUT_CTRL) |->
        ##2 clock_out_drive_select == $past(reg_wdata[5:4], 2)) else $error("drive code");
    AST_TRIM: assert property (s_wr(ROC_ADDR_OSC_CTRL) |->
        ##2 osc_load_trim == $past(reg_wdata[3:0], 2)) else $error("trim code");
    AST_SRC: assert property (src_age_q == 2'h3 |->
        ext_ref_select == (osc_source_select == ROC_SRC_EXTERNAL)) else $error("ext ref");
    AST_OSC_EN: assert property (src_age_q == 2'h3 && osc_enable |->
        osc_source_select == ROC_SRC_CRYSTAL) else $error("oscillator enable");
    AST_HIGH_MIN: assert property ($rose(master_clock_out_pin) |=> master_clock_out_pin[*2])
        else $error("runt high pulse");
    AST_LOW_MIN: assert property ($fell(master_clock_out_pin) |=> !master_clock_out_pin[*2])
        else $error("runt low pulse");
    AST_WAKE: assert property ($fell(sleep_pin) |=> !ref_ready[*8])
        else $error("ready too soon after wake");
    AST_SETTLE: assert property ($rose(ref_ready) |-> !$past(sleep_pin, SETTLE_CYCLES))
        else $error("ready without settling time");
endmodule
bind roc_clk_out_ctrl roc_clk_out_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.*);

// *** tb/roc_host_model.sv ***
// host model clocked from the output pin: timestamps its rising edges
// assumes the bench flushes it after each rate change
`timescale 1ns/1ps
module roc_host_model (
    // clock from the device
    input wire logic master_clock_out_pin,
    input wire logic ref_ready
);
    longint edges[$];
    int     edge_count = 0;
    task automatic flush();
        edges.delete();
    endtask
    always @(posedge master_clock_out_pin) begin
        edge_count++;
        if (ref_ready) edges.push_back($time);
        if (edges.size() > 9) void'(edges.pop_front());
    end
endmodule
